// *** verilog/code_rom_security_lock.sv ***
// Purpose: Protection logic for on-chip code ROM: lock bits, verify gate,
//          table-read gate, key scrambling and programming inhibit.
// Assumes: Code store lives outside; this block gates its read paths.
// Notes:   Lock state is captured while reset is asserted, so every
//          restriction is in force at the first edge after release.
//          Reads take two edges: store address, then gated answer.
//          Lock byte writes stay open after locking; bits only add.
//          Key contents reach only the verify scrambler.
// Contract
// R1 - No lock bits: whole code verifiable
// R2 - Written key: verify returns encrypted bytes
// R3 - First bit: external table reads blocked
// R4 - First bit: external-access latched at reset
// R5 - First bit: further programming refused
// R6 - Both bits: first-bit limits plus no verify
// R7 - Second bit never set without first
// R8 - Only three lock patterns are defined
// R9 - Key has 64 bytes, erased all ones
// R10 - Small variant: 4k code, key, locks
// R11 - Large variant: 8k code, key, locks
// R12 - Encrypted byte is code XNOR key byte
// R13 - Key contents never readable
// R14 - Image: code, then key, then lock byte
// R15 - Locks captured in reset before fetch
module code_rom_security_lock
  import rom_lock_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
)
(
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  // Non-volatile lock byte and external-access pin
  input  wire logic [7:0]             lock_byte_in,
  input  wire logic                   external_access_select_in,
  // Programmer requests
  input  wire prog_req_t              prog_in,
  input  wire verify_req_t            verify_in,
  // Programming answers
  output logic                        prog_code_we_out,
  output logic [CODE_ADDR_W-1:0]      prog_code_addr_out,
  output logic [7:0]                  prog_code_data_out,
  output logic                        prog_lock_we_out,
  output logic [7:0]                  prog_lock_data_out,
  output logic                        prog_refused_out,
  // Verify answers
  output logic                        verify_valid_out,
  output logic [7:0]                  verify_data_out,
  // CPU table reads
  input  wire table_req_t             table_in,
  output logic                        table_valid_out,
  output logic [7:0]                  table_data_out,
  // Protection levels seen by the CPU
  output logic                        ext_select_latched_out,
  output logic                        lock_first_out,
  output logic                        lock_second_out,
  // Code store read port
  output logic [CODE_ADDR_W-1:0]      rom_addr_out,
  input  wire logic [7:0]             rom_data_in
);

  localparam int unsigned CODE_BYTES = LARGE_VARIANT ? LARGE_CODE_BYTES
                                                     : SMALL_CODE_BYTES; // R10 R11
  // Image offsets of the key and the lock byte
  localparam logic [IMG_ADDR_W-1:0] KEY_BASE  = IMG_ADDR_W'(CODE_BYTES);
  localparam logic [IMG_ADDR_W-1:0] LOCK_ADDR = IMG_ADDR_W'(CODE_BYTES + KEY_BYTES);

  typedef struct packed {
    // Lock bits latched at reset; select latched only with the first bit
    lock_state_t            lock;
    // Programming answer
    logic                   code_we;
    logic [CODE_ADDR_W-1:0] code_addr;
    logic [7:0]             code_data;
    logic                   lock_we;
    logic [7:0]             lock_data;
    logic                   refused;
    // Verify pipeline
    logic                   ver_pend;
    logic                   ver_valid;
    logic [7:0]             ver_data;
    // Table read pipeline
    logic                   tab_pend;
    logic                   tab_block;
    logic                   tab_valid;
    logic [7:0]             tab_data;
    // Store address and key tap
    logic [CODE_ADDR_W-1:0] rom_addr;
    logic [KEY_IDX_W-1:0]   key_idx;
  } ctl_state_t;

  ctl_state_t state_reg;
  ctl_state_t state_next;

  // Key write decode and scrambler tap
  logic                 key_we;
  logic [KEY_IDX_W-1:0] key_wr_idx;
  logic [7:0]           key_byte;
  logic                 key_written;
  logic                 in_code;
  logic                 in_key;
  logic                 at_lock;

  always_comb begin
    in_code    = prog_in.addr < KEY_BASE; // R14
    in_key     = (prog_in.addr >= KEY_BASE) && (prog_in.addr < LOCK_ADDR);
    at_lock    = prog_in.addr == LOCK_ADDR;

    // Key writes blocked once locked; the request is refused
    key_wr_idx = KEY_IDX_W'(prog_in.addr - KEY_BASE);
    key_we     = prog_in.valid && in_key && !state_reg.lock.first_lock_bit; // R5
  end

  // Key store; its read port only feeds the scrambler
  key_array u_key (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .wr_en_in    (key_we),
    .wr_idx_in   (key_wr_idx),
    .wr_data_in  (prog_in.data),
    .rd_idx_in   (state_reg.key_idx),
    .rd_data_out (key_byte), // R13
    .written_out (key_written)
  );

  // Next-state logic
  always_comb begin
    state_next           = state_reg;
    state_next.code_we   = 1'b0;
    state_next.lock_we   = 1'b0;
    state_next.refused   = 1'b0;
    state_next.ver_valid = 1'b0;
    state_next.tab_valid = 1'b0;
    state_next.ver_pend  = 1'b0;
    state_next.tab_pend  = 1'b0;

    // Select pin follows live until the first lock freezes it
    if (!state_reg.lock.first_lock_bit) begin
      state_next.lock.ext_select_latched = external_access_select_in; // R4
    end

    // Programming: code and key blocked once first bit set, lock bits allowed
    if (prog_in.valid) begin
      if (at_lock) begin
        state_next.lock_we   = 1'b1;
        state_next.lock_data = lock_byte_in | prog_in.data;
      end else if (state_reg.lock.first_lock_bit) begin
        state_next.refused = 1'b1; // R5
      end else if (in_code) begin
        state_next.code_we   = 1'b1;
        state_next.code_addr = prog_in.addr[CODE_ADDR_W-1:0];
        state_next.code_data = prog_in.data;
      end else if (!in_key) begin
        state_next.refused = 1'b1;
      end
    end

    // Stage two: deliver results read from the code store
    if (state_reg.ver_pend) begin
      state_next.ver_valid = 1'b1;
      // Blocked readout wins over scrambling
      if (state_reg.lock.second_lock_bit) begin
        state_next.ver_data = VERIFY_BLOCKED; // R6
      end else if (key_written) begin
        state_next.ver_data = ~(rom_data_in ^ key_byte); // R2 R12
      end else begin
        state_next.ver_data = rom_data_in; // R1
      end
    end else if (state_reg.tab_pend) begin
      state_next.tab_valid = 1'b1;
      state_next.tab_data  = state_reg.tab_block ? TABLE_BLOCKED : rom_data_in; // R3
    end

    // Stage one: accept a request; verify has priority over CPU reads
    // A table read in the same cycle as a verify is dropped
    if (verify_in.valid) begin
      state_next.ver_pend = 1'b1;
      state_next.rom_addr = verify_in.addr;
      state_next.key_idx  = verify_in.addr[KEY_IDX_W-1:0];
    end else if (table_in.valid) begin
      state_next.tab_pend  = 1'b1;
      state_next.rom_addr  = table_in.addr;
      state_next.tab_block = table_in.from_external
                             && state_reg.lock.first_lock_bit; // R3
    end
  end

  // State register; lock state captured while reset is held
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      // Pending work dropped; locks sampled on every reset edge
      state_reg                      <= '0;
      state_reg.lock.first_lock_bit  <= lock_byte_in[LOCK_FIRST_POS]; // R15
      // Second bit only honoured with the first; other patterns undefined
      state_reg.lock.second_lock_bit <= lock_byte_in[LOCK_SECOND_POS]
                                        & lock_byte_in[LOCK_FIRST_POS]; // R7 R8
      state_reg.lock.ext_select_latched <= external_access_select_in; // R4
    end else begin
      state_reg <= state_next;
    end
  end

  // Programming outputs straight from flops
  assign prog_code_we_out   = state_reg.code_we;
  assign prog_code_addr_out = state_reg.code_addr;
  assign prog_code_data_out = state_reg.code_data;
  assign prog_lock_we_out   = state_reg.lock_we;
  assign prog_lock_data_out = state_reg.lock_data;
  assign prog_refused_out   = state_reg.refused;

  // Read answers straight from flops
  assign verify_valid_out   = state_reg.ver_valid;
  assign verify_data_out    = state_reg.ver_data;
  assign table_valid_out    = state_reg.tab_valid;
  assign table_data_out     = state_reg.tab_data;

  // Protection levels straight from flops
  assign ext_select_latched_out = state_reg.lock.ext_select_latched;
  assign lock_first_out     = state_reg.lock.first_lock_bit;
  assign lock_second_out    = state_reg.lock.second_lock_bit;

  // Store address straight from its flop
  assign rom_addr_out       = state_reg.rom_addr;

endmodule

// *** verilog/rom_lock_pkg.sv ***
// Purpose: Shared constants and carriers for the code ROM protection block.
// Assumes: Byte-wide code store, 64-byte key, lock byte after the key.
// Notes:   Image layout constants serve both size variants.
package rom_lock_pkg;

  // Code size variants, in bytes
  localparam int unsigned SMALL_CODE_BYTES = 4096;
  localparam int unsigned LARGE_CODE_BYTES = 8192;
  localparam int unsigned CODE_ADDR_W      = 13;

  // Key array geometry and erased value
  localparam int unsigned KEY_BYTES  = 64;
  localparam int unsigned KEY_IDX_W  = 6;
  localparam logic [7:0]  KEY_ERASED = 8'hff;

  // Lock byte field positions
  localparam int unsigned LOCK_FIRST_POS  = 0;
  localparam int unsigned LOCK_SECOND_POS = 1;

  // Image layout: key follows code, lock byte follows key
  localparam int unsigned IMG_ADDR_W = 14;

  // Value shown on the verify port when readout is blocked
  localparam logic [7:0] VERIFY_BLOCKED = 8'hff;

  // Value returned to the CPU for a blocked table read
  localparam logic [7:0] TABLE_BLOCKED = 8'h00;

  // Programming write carrier
  typedef struct packed {
    logic                  valid;
    logic [IMG_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } prog_req_t;

  // Verify request carrier
  typedef struct packed {
    logic                   valid;
    logic [CODE_ADDR_W-1:0] addr;
  } verify_req_t;

  // CPU code-table read carrier
  typedef struct packed {
    logic                   valid;
    logic                   from_external;
    logic [CODE_ADDR_W-1:0] addr;
  } table_req_t;

  // Protection controls: lock bits latched at reset, select latched only with the first bit
  typedef struct packed {
    logic first_lock_bit;
    logic second_lock_bit;
    logic ext_select_latched;
  } lock_state_t;

endpackage

// *** verilog/key_array.sv ***
// Purpose: 64-byte encryption key store with a single indexed read.
// Assumes: Read port feeds only the verify scrambler, never a pin.
// Notes:   All bytes erased to ones at reset.
module key_array
  import rom_lock_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  // Write port
  input  wire logic                 wr_en_in,
  input  wire logic [KEY_IDX_W-1:0] wr_idx_in,
  input  wire logic [7:0]           wr_data_in,
  // Read port for scrambling only
  input  wire logic [KEY_IDX_W-1:0] rd_idx_in,
  output logic      [7:0]           rd_data_out,
  output logic                      written_out
);

  typedef struct packed {
    logic [KEY_BYTES-1:0][7:0] key;
    logic                      written;
  } key_state_t;

  key_state_t state_reg;
  key_state_t state_next;

  // Next state: one byte written per request
  always_comb begin
    state_next = state_reg;
    if (wr_en_in) begin
      state_next.key[wr_idx_in] = wr_data_in;
      state_next.written        = 1'b1;
    end
  end

  // State register, erased to all ones
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < KEY_BYTES; i++) begin
        state_reg.key[i] <= KEY_ERASED; // R9
      end
      state_reg.written <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_out = state_reg.key[rd_idx_in];
  assign written_out = state_reg.written;

endmodule

// *** tb/code_store_model.sv ***
// Purpose: Behavioural code store answering the protection block's reads.
// Assumes: Read data is combinational from the registered address.
// Notes:   Content is a fixed address pattern the bench can predict.
module code_store_model
(
  // Read port
  input  wire logic [12:0] addr_in,
  output logic      [7:0]  data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Every address of both sizes holds a byte; no write path
  assign data_out = addr_in[7:0] ^ {3'h0, addr_in[12:8]} ^ 8'h3c;
endmodule

// *** tb/code_rom_security_lock_chk.sv ***
// Purpose: Port checks of answer timing and lock gating.
// Assumes: Registered answers, two cycles for reads, one for writes.
// Notes:   Bound to every protection block instance.
module code_rom_security_lock_chk
  import rom_lock_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
)
(
  // Clock, reset and requests
  input wire logic                   clk_in,
  input wire logic                   reset_n_in,
  input wire prog_req_t              prog_in,
  input wire verify_req_t            verify_in,
  input wire table_req_t             table_in,
  // Answers and lock levels
  input wire logic                   prog_code_we_out,
  input wire logic                   prog_refused_out,
  input wire logic                   verify_valid_out,
  input wire logic [7:0]             verify_data_out,
  input wire logic                   table_valid_out,
  input wire logic [7:0]             table_data_out,
  input wire logic                   ext_select_latched_out,
  input wire logic                   lock_first_out,
  input wire logic                   lock_second_out,
  input wire logic [CODE_ADDR_W-1:0] rom_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lock byte sits right after code and key
  localparam int unsigned LOCK_ADDR =
    (LARGE_VARIANT ? LARGE_CODE_BYTES : SMALL_CODE_BYTES) + KEY_BYTES;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Read answers arrive two cycles after the request
  sequence verify_ans_s;
    ##2 verify_valid_out;
  endsequence
  sequence table_ans_s;
    ##2 table_valid_out;
  endsequence
  verify_lat_a: assert property (verify_in.valid |-> verify_ans_s)
    else $error("verify answer missing");
  verify_block_a: assert property (verify_in.valid && lock_first_out && lock_second_out
    |-> verify_ans_s ##0 verify_data_out == VERIFY_BLOCKED) else $error("verify not blocked");
  table_block_a: assert property (table_in.valid && table_in.from_external &&
    !verify_in.valid && lock_first_out |-> table_ans_s ##0 table_data_out == TABLE_BLOCKED)
    else $error("external table read not blocked");
  prog_refuse_a: assert property (prog_in.valid && lock_first_out && prog_in.addr < LOCK_ADDR
    |=> prog_refused_out && !prog_code_we_out) else $error("write not refused");
  refuse_cause_a: assert property (prog_refused_out |-> $past(prog_in.valid))
    else $error("refusal without request");
  select_hold_a: assert property (lock_first_out && $past(reset_n_in)
    |-> $stable(ext_select_latched_out)) else $error("latched select moved");
  lock_hold_a: assert property ($past(reset_n_in)
    |-> $stable({lock_first_out, lock_second_out})) else $error("lock level moved");
  rom_addr_a: assert property (verify_in.valid |=> rom_addr_out == $past(verify_in.addr))
    else $error("store address wrong");
endmodule
bind code_rom_security_lock code_rom_security_lock_chk #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (.*);

// *** tb/code_rom_security_lock_test.sv ***
// Purpose: Directed tests of lock gating, key scrambling and refusal.
// Assumes: Small variant; store content from the model's address pattern.
// Notes:   Key array is erased by every reset.
module code_rom_security_lock_test
  import rom_lock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] lock_byte_in = 8'h00;
  logic external_access_select_in = 1'b0;
  prog_req_t prog_in = '0;
  verify_req_t verify_in = '0;
  table_req_t table_in = '0;
  logic prog_code_we_out, prog_lock_we_out, prog_refused_out, verify_valid_out;
  logic table_valid_out, ext_select_latched_out, lock_first_out, lock_second_out;
  logic [CODE_ADDR_W-1:0] prog_code_addr_out, rom_addr_out;
  logic [7:0] prog_code_data_out, prog_lock_data_out, verify_data_out, table_data_out, rom_data_in;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  code_rom_security_lock u_code_rom_security_lock (.*);
  code_store_model u_code_store_model (.addr_in(rom_addr_out), .data_out(rom_data_in));
  always #5 clk_in = ~clk_in;
  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      finish_test();
    end
  end
  function automatic logic [7:0] rom(input logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]} ^ 8'h3c;
  endfunction
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Lock settings never carry the second bit alone
  task automatic do_reset(input logic [7:0] lk, input logic sel);
    reset_n_in = 1'b0;
    lock_byte_in = lk;
    external_access_select_in = sel;
    repeat (4) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
  endtask
  // Verify or table read, answer two cycles on
  task automatic rd(input logic tbl, input logic ext, input logic [12:0] a, input logic [7:0] e);
    if (tbl) table_in = '{1'b1, ext, a};
    else verify_in = '{1'b1, a};
    tick();
    table_in.valid = 1'b0;
    verify_in.valid = 1'b0;
    tick();
    check(tbl ? table_valid_out : verify_valid_out, 1'b1);
    check(tbl ? table_data_out : verify_data_out, e);
  endtask
  // Image write; e is {code write, lock write, refused}
  task automatic prog(input logic [13:0] a, input logic [7:0] d, input logic [2:0] e);
    prog_in = '{1'b1, a, d};
    tick();
    prog_in.valid = 1'b0;
    check({prog_code_we_out, prog_lock_we_out, prog_refused_out}, e);
    if (e[2]) check({prog_code_addr_out, prog_code_data_out}, {a[12:0], d});
    if (e[1]) check(prog_lock_data_out, lock_byte_in | d);
    tick();
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    do_reset(8'h00, 1'b1);
    check({lock_first_out, lock_second_out, ext_select_latched_out}, 3'b001);
    rd(1'b0, 1'b0, 13'h000, rom(13'h000));
    rd(1'b0, 1'b0, 13'hfff, rom(13'hfff));
    rd(1'b1, 1'b1, 13'h010, rom(13'h010));
    prog(14'h0005, 8'ha5, 3'b100);
    prog(14'h1040, 8'h01, 3'b010);
    prog(14'h1041, 8'h00, 3'b001);
    prog(14'h1003, 8'h5a, 3'b000);
    rd(1'b0, 1'b0, 13'h003, ~(rom(13'h003) ^ 8'h5a));
    rd(1'b0, 1'b0, 13'h043, ~(rom(13'h043) ^ 8'h5a));
    rd(1'b0, 1'b0, 13'h004, rom(13'h004));
    rd(1'b1, 1'b0, 13'h003, rom(13'h003));
    do_reset(8'h01, 1'b0);
    check({lock_first_out, lock_second_out, ext_select_latched_out}, 3'b100);
    external_access_select_in = 1'b1;
    tick();
    tick();
    check(ext_select_latched_out, 1'b0);
    prog(14'h0005, 8'ha5, 3'b001);
    prog(14'h1003, 8'h00, 3'b001);
    rd(1'b1, 1'b1, 13'h010, TABLE_BLOCKED);
    rd(1'b1, 1'b0, 13'h010, rom(13'h010));
    rd(1'b0, 1'b0, 13'h010, rom(13'h010));
    do_reset(8'h03, 1'b1);
    check({lock_first_out, lock_second_out, ext_select_latched_out}, 3'b111);
    rd(1'b0, 1'b0, 13'h010, VERIFY_BLOCKED);
    rd(1'b1, 1'b1, 13'h010, TABLE_BLOCKED);
    prog(14'h0000, 8'h11, 3'b001);
    prog(14'h1040, 8'h02, 3'b010);
    finish_test();
  end
endmodule
